/* File: lan_ctl_pkg.sv */
package lan_ctl_pkg;
  // ----------------------------------------
  // Register map (byte offset on the plain port)
  // ----------------------------------------
  localparam logic [7:0] ADDR_HOST_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CONFIG_CTRL = 8'h48;
  localparam logic [7:0] ADDR_POWER_STATUS = 8'h50;
  localparam logic [7:0] ADDR_XCVR_CTRL = 8'h80;
  localparam logic [7:0] ADDR_XCVR_ADV = 8'h84;
  localparam logic [7:0] ADDR_LINK_STATUS = 8'h88;
  localparam logic [7:0] ADDR_STATION_LO = 8'h8c;
  localparam logic [7:0] ADDR_STATION_HI = 8'h90;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int HOST_SW_RESET_BIT = 0;
  localparam int CFG_WAKE_EN_BIT = 18;
  localparam int CFG_LED4_BIT = 0;
  localparam int PWR_WAKE_STATUS_BIT = 15;
  localparam int XC_RESET_BIT = 15;
  localparam int XC_LOOPBACK_BIT = 14;
  localparam int XC_SPEED_BIT = 13;
  localparam int XC_ANEG_EN_BIT = 12;
  localparam int XC_DUPLEX_BIT = 8;
  localparam int ADV_PAUSE_BIT = 10;
  localparam int ADV_100FD_BIT = 8;
  localparam int ADV_100HD_BIT = 7;
  localparam int ADV_10FD_BIT = 6;
  localparam int ADV_10HD_BIT = 5;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [15:0] XCVR_CTRL_RESET = 16'h3100;
  localparam logic [15:0] XCVR_ADV_RESET = 16'h05e1;
  localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
  localparam logic [47:0] STATION_RESET = 48'h0000_0000_0000;

  // ----------------------------------------
  // Frame constants
  // ----------------------------------------
  localparam logic [15:0] PAUSE_OPCODE = 16'h0001;
  localparam logic [15:0] CTRL_TYPE = 16'h8808;
  localparam logic [4:0] CODE_IDLE = 5'h1f;
  localparam logic [4:0] CODE_ESD_T = 5'h0d;
  localparam int CS_WINDOW = 10;
  localparam int WAKE_FF_COUNT = 6;
  localparam int WAKE_ADDR_COUNT = 16;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int SLOT_BITS = 512;
  localparam int SLOT_NS_100 = 5120;
  localparam int SLOT_NS_10 = 51200;
  localparam int SLOT_CYC_100 = SLOT_NS_100 * CLK_MHZ / 1000;
  localparam int SLOT_CYC_10 = SLOT_NS_10 * CLK_MHZ / 1000;
  localparam int BLINK10_MS = 50;
  localparam int BLINK20_MS = 25;
  localparam int BLINK10_CYC = BLINK10_MS * CLK_MHZ * 1000;
  localparam int BLINK20_CYC = BLINK20_MS * CLK_MHZ * 1000;

  typedef enum logic [1:0] {
    ANEG_IDLE,
    ANEG_SEND,
    ANEG_DONE
  } aneg_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic valid;
    logic sof;
    logic eof;
    logic crc_ok;
    logic addr_ok;
    logic [7:0] data;
  } rx_byte_t;
endpackage

/* File: lan_link_flow_wake_control.sv */
// Decided for this implementation: the plain strobed port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
// Contract
// - Carrier rises on two non-adjacent zeros inside any ten-bit window.
// - Carrier falls on end-of-stream or idle code-group.
// - Half duplex: carrier on transmit or receive; full duplex: receive only.
// - Collision ignored in full duplex; in half duplex on transmit-receive overlap.
// - Control bit 14 enables loop-back; line then carries only idle.
// - Loop-back path taken at coder level per speed.
// - Control bit 12 enables auto-negotiation.
// - Link pulse burst carries the 16-bit advertisement word.
// - Resolve highest common ability: 100FD, 100HD, 10FD, 10HD.
// - Negotiate right after reset if enabled, else wait for enable write.
// - Negotiation off: speed and duplex from control register.
// - Pause active only after negotiation with full duplex and pause ability.
// - Control frame with opcode 0001h is pause; parameter is slot count.
// - Valid pause loads timer; paused until zero; zero ends pause at once.
// - Frame in progress finishes; no new frame starts after one slot.
// - Three-LED mode: speed, link or activity 10 Hz, duplex or collision 20 Hz.
// - Four-LED mode: 100 link, 10 link, activity 10 Hz, duplex or collision.
// - Host control bit 0 resets whole block, then self-clears.
// - Control bit 15 resets transceiver only, then self-clears.
// - Wake frame: filtered, good CRC, six FF then sixteen station addresses.
// - Wake enabled and wake frame: drive event line low, set status bit 15.
module lan_link_flow_wake_control
  import lan_ctl_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic i_rx_bit,
  input wire logic [4:0] i_rx_code,
  input wire logic i_rx_code_valid,
  input wire logic i_tx_active,
  input wire logic i_tx_frame_req,
  output logic o_tx_frame_go,
  input wire logic i_tx_line_bit,
  output logic o_line_bit,
  output logic o_line_idle,
  output logic o_loop_bit,
  output logic o_loop_100,
  input wire logic i_link_up,
  input wire logic i_partner_valid,
  input wire logic [15:0] i_partner_ability,
  output logic o_flp_send,
  output logic [15:0] o_flp_word,
  output logic o_crs,
  output logic o_col,
  input wire logic i_rx_valid,
  input wire logic i_rx_sof,
  input wire logic i_rx_eof,
  input wire logic i_rx_crc_ok,
  input wire logic i_rx_addr_ok,
  input wire logic [7:0] i_rx_data,
  output logic o_paused,
  output logic o_led_speed,
  output logic o_led_link_act,
  output logic o_led_fd_col,
  output logic o_led_link100,
  output logic o_led_link10,
  output logic o_led_act,
  output logic o_pme_n,
  output logic o_xcvr_reset
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [31:0] rdata;
    logic [15:0] xc;
    logic [15:0] adv;
    logic [31:0] cfg;
    logic wake_status;
    logic [47:0] station;
    logic [CS_WINDOW-1:0] win;
    logic crs_rx;
    aneg_state_t aneg;
    logic res_100;
    logic res_fd;
    logic res_pause;
    logic [15:0] pause_cnt;
    logic [12:0] slot_cyc;
    logic [12:0] grace;
    logic in_tx;
    logic [10:0] bcnt;
    logic is_ctrl;
    logic is_pause;
    logic [15:0] pause_val;
    logic [4:0] ff_run;
    logic [2:0] apos;
    logic [4:0] acnt;
    logic wake_hit;
    logic [23:0] blink;
    logic soft_rst;
  } state_t;

  state_t cur, next_cur;
  rx_byte_t rxb;

  function automatic logic two_sep_zeros(input logic [CS_WINDOW-1:0] w);
    logic found;
    found = 1'b0;
    for (int i = 0; i < CS_WINDOW; i++) begin
      for (int j = i + 2; j < CS_WINDOW; j++) begin
        if (!w[i] && !w[j]) begin
          found = 1'b1;
        end
      end
    end
    return found;
  endfunction

  function automatic logic [7:0] station_byte(input logic [47:0] s, input logic [2:0] k);
    return s[8*k +: 8];
  endfunction

  logic [15:0] common;
  logic eff_100, eff_fd, pause_en, collide, act;
  logic [12:0] slot_len;

  always_comb begin
    rxb = '{valid: i_rx_valid, sof: i_rx_sof, eof: i_rx_eof, crc_ok: i_rx_crc_ok,
            addr_ok: i_rx_addr_ok, data: i_rx_data};
    common = cur.adv & i_partner_ability;
    eff_100 = cur.xc[XC_ANEG_EN_BIT] ? cur.res_100 : cur.xc[XC_SPEED_BIT];
    eff_fd = cur.xc[XC_ANEG_EN_BIT] ? cur.res_fd : cur.xc[XC_DUPLEX_BIT];
    pause_en = cur.xc[XC_ANEG_EN_BIT] && (cur.aneg == ANEG_DONE)
               && cur.res_fd && cur.res_pause;
    collide = !eff_fd && i_tx_active && cur.crs_rx;
    act = i_tx_active || cur.crs_rx;
    slot_len = eff_100 ? 13'(SLOT_CYC_100) : 13'(SLOT_CYC_10);
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_cur = cur;
    next_cur.rdata = 32'h0000_0000;
    next_cur.soft_rst = 1'b0;
    // Register writes
    if (i_wr) begin
      if (i_addr == ADDR_HOST_CTRL) begin
        next_cur.soft_rst = i_wdata[HOST_SW_RESET_BIT];
      end else if (i_addr == ADDR_CONFIG_CTRL) begin
        next_cur.cfg = i_wdata;
      end else if (i_addr == ADDR_POWER_STATUS) begin
        if (i_wdata[PWR_WAKE_STATUS_BIT]) begin
          next_cur.wake_status = 1'b0;
        end
      end else if (i_addr == ADDR_XCVR_CTRL) begin
        next_cur.xc = i_wdata[15:0];
        if (i_wdata[XC_ANEG_EN_BIT] && !cur.xc[XC_ANEG_EN_BIT]) begin
          next_cur.aneg = ANEG_SEND;
        end
      end else if (i_addr == ADDR_XCVR_ADV) begin
        next_cur.adv = i_wdata[15:0];
      end else if (i_addr == ADDR_STATION_LO) begin
        next_cur.station[31:0] = i_wdata;
      end else if (i_addr == ADDR_STATION_HI) begin
        next_cur.station[47:32] = i_wdata[15:0];
      end
    end
    // Register reads
    if (i_rd) begin
      if (i_addr == ADDR_HOST_CTRL) begin
        next_cur.rdata = 32'h0000_0000;
      end else if (i_addr == ADDR_CONFIG_CTRL) begin
        next_cur.rdata = cur.cfg;
      end else if (i_addr == ADDR_POWER_STATUS) begin
        next_cur.rdata = {16'h0000, cur.wake_status, 15'h0000};
      end else if (i_addr == ADDR_XCVR_CTRL) begin
        next_cur.rdata = {16'h0000, cur.xc};
      end else if (i_addr == ADDR_XCVR_ADV) begin
        next_cur.rdata = {16'h0000, cur.adv};
      end else if (i_addr == ADDR_LINK_STATUS) begin
        next_cur.rdata = {24'h000000, o_paused, pause_en, cur.crs_rx, eff_fd, eff_100,
                          cur.aneg == ANEG_DONE, i_link_up, 1'b0};
      end else if (i_addr == ADDR_STATION_LO) begin
        next_cur.rdata = cur.station[31:0];
      end else if (i_addr == ADDR_STATION_HI) begin
        next_cur.rdata = {16'h0000, cur.station[47:32]};
      end
    end

    // Carrier sense on the receive stream
    next_cur.win = {cur.win[CS_WINDOW-2:0], i_rx_bit};
    if (i_rx_code_valid && (i_rx_code == CODE_IDLE || i_rx_code == CODE_ESD_T)) begin
      next_cur.crs_rx = 1'b0;
    end else if (two_sep_zeros(cur.win)) begin
      next_cur.crs_rx = 1'b1;
    end

    // Auto-negotiation
    case (cur.aneg)
      ANEG_IDLE: begin
        if (cur.xc[XC_ANEG_EN_BIT]) begin
          next_cur.aneg = ANEG_SEND;
        end
      end
      ANEG_SEND: begin
        if (!cur.xc[XC_ANEG_EN_BIT]) begin
          next_cur.aneg = ANEG_IDLE;
        end else if (i_partner_valid) begin
          next_cur.aneg = ANEG_DONE;
          next_cur.res_pause = common[ADV_PAUSE_BIT];
          if (common[ADV_100FD_BIT]) begin
            next_cur.res_100 = 1'b1;
            next_cur.res_fd = 1'b1;
          end else if (common[ADV_100HD_BIT]) begin
            next_cur.res_100 = 1'b1;
            next_cur.res_fd = 1'b0;
          end else if (common[ADV_10FD_BIT]) begin
            next_cur.res_100 = 1'b0;
            next_cur.res_fd = 1'b1;
          end else begin
            next_cur.res_100 = 1'b0;
            next_cur.res_fd = 1'b0;
          end
        end
      end
      default: begin
        if (!cur.xc[XC_ANEG_EN_BIT]) begin
          next_cur.aneg = ANEG_IDLE;
        end
      end
    endcase

    // Receive frame parser: pause and wake patterns
    if (rxb.valid) begin
      next_cur.bcnt = rxb.sof ? 11'd1 : cur.bcnt + 11'd1;
      if (rxb.sof) begin
        next_cur.is_ctrl = 1'b0;
        next_cur.is_pause = 1'b0;
        next_cur.wake_hit = 1'b0;
        next_cur.ff_run = 5'd0;
        next_cur.acnt = 5'd0;
        next_cur.apos = 3'd0;
      end
      if (cur.bcnt == 11'd12) begin
        next_cur.is_ctrl = (rxb.data == CTRL_TYPE[15:8]);
      end
      if (cur.bcnt == 11'd13) begin
        next_cur.is_ctrl = cur.is_ctrl && (rxb.data == CTRL_TYPE[7:0]);
      end
      if (cur.bcnt == 11'd15) begin
        next_cur.is_pause = cur.is_ctrl && (rxb.data == PAUSE_OPCODE[7:0]);
      end
      if (cur.bcnt == 11'd14 && rxb.data != PAUSE_OPCODE[15:8]) begin
        next_cur.is_ctrl = 1'b0;
      end
      if (cur.bcnt == 11'd16) begin
        next_cur.pause_val[15:8] = rxb.data;
      end
      if (cur.bcnt == 11'd17) begin
        next_cur.pause_val[7:0] = rxb.data;
      end
      // Wake pattern search, restarts on any break
      if (cur.ff_run >= 5'(WAKE_FF_COUNT) && rxb.data == station_byte(cur.station, 3'd5 - cur.apos)) begin
        next_cur.apos = (cur.apos == 3'd5) ? 3'd0 : cur.apos + 3'd1;
        if (cur.apos == 3'd5) begin
          next_cur.acnt = cur.acnt + 5'd1;
          if (cur.acnt == 5'(WAKE_ADDR_COUNT - 1)) begin
            next_cur.wake_hit = 1'b1;
          end
        end
        if (rxb.data != 8'hff) begin
          next_cur.ff_run = 5'(WAKE_FF_COUNT);
        end
      end else if (rxb.data == 8'hff) begin
        next_cur.ff_run = (cur.ff_run >= 5'(WAKE_FF_COUNT)) ? cur.ff_run : cur.ff_run + 5'd1;
        next_cur.apos = 3'd0;
        next_cur.acnt = 5'd0;
      end else begin
        next_cur.ff_run = 5'd0;
        next_cur.apos = 3'd0;
        next_cur.acnt = 5'd0;
      end
    end

    // Pause timer
    if (cur.pause_cnt != 16'h0000) begin
      if (cur.slot_cyc + 13'd1 >= slot_len) begin
        next_cur.slot_cyc = 13'd0;
        next_cur.pause_cnt = cur.pause_cnt - 16'd1;
      end else begin
        next_cur.slot_cyc = cur.slot_cyc + 13'd1;
      end
    end
    if (cur.grace != 13'd0) begin
      next_cur.grace = cur.grace - 13'd1;
    end
    if (rxb.valid && rxb.eof && rxb.crc_ok && rxb.addr_ok) begin
      if (cur.is_pause && pause_en) begin
        next_cur.pause_cnt = {cur.pause_val[15:8], rxb.data};
        next_cur.slot_cyc = 13'd0;
        next_cur.grace = ({cur.pause_val[15:8], rxb.data} != 16'h0000) ? slot_len : 13'd0;
      end
      if ((cur.wake_hit || next_cur.wake_hit) && cur.cfg[CFG_WAKE_EN_BIT]) begin
        next_cur.wake_status = 1'b1;
      end
    end
    if (!pause_en) begin
      next_cur.pause_cnt = 16'h0000;
    end

    // Transmit start gate: ongoing frame runs on
    if (!i_tx_active) begin
      next_cur.in_tx = 1'b0;
    end else if (o_tx_frame_go) begin
      next_cur.in_tx = 1'b1;
    end

    // LED blink base
    next_cur.blink = (cur.blink >= 24'(2 * BLINK10_CYC - 1)) ? 24'd0 : cur.blink + 24'd1;

    // Transceiver-only reset, self-clearing
    if (cur.xc[XC_RESET_BIT]) begin
      next_cur.xc = XCVR_CTRL_RESET;
      next_cur.adv = XCVR_ADV_RESET;
      next_cur.aneg = ANEG_IDLE;
      next_cur.crs_rx = 1'b0;
      next_cur.res_100 = 1'b0;
      next_cur.res_fd = 1'b0;
      next_cur.res_pause = 1'b0;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      cur <= '0;
      cur.xc <= XCVR_CTRL_RESET;
      cur.adv <= XCVR_ADV_RESET;
      cur.cfg <= CONFIG_RESET;
      cur.station <= STATION_RESET;
      cur.win <= '1;
      cur.aneg <= ANEG_IDLE;
    end else if (cur.soft_rst) begin
      cur <= '0;
      cur.xc <= XCVR_CTRL_RESET;
      cur.adv <= XCVR_ADV_RESET;
      cur.cfg <= CONFIG_RESET;
      cur.station <= STATION_RESET;
      cur.win <= '1;
      cur.aneg <= ANEG_IDLE;
    end else begin
      cur <= next_cur;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  logic blink10, blink20;

  always_comb begin
    blink10 = cur.blink < 24'(BLINK10_CYC);
    blink20 = (cur.blink < 24'(BLINK20_CYC))
              || ((cur.blink >= 24'(BLINK10_CYC)) && (cur.blink < 24'(BLINK10_CYC + BLINK20_CYC)));
    o_rdata = cur.rdata;
    o_crs = eff_fd ? cur.crs_rx : (cur.crs_rx || i_tx_active);
    o_col = collide;
    o_paused = cur.pause_cnt != 16'h0000;
    o_tx_frame_go = i_tx_frame_req && !cur.in_tx
                    && (!o_paused || cur.grace != 13'd0);
    o_line_idle = cur.xc[XC_LOOPBACK_BIT] || !i_tx_active;
    o_line_bit = cur.xc[XC_LOOPBACK_BIT] ? 1'b0 : i_tx_line_bit;
    o_loop_bit = cur.xc[XC_LOOPBACK_BIT] && i_tx_line_bit;
    o_loop_100 = eff_100;
    o_flp_send = cur.aneg == ANEG_SEND;
    o_flp_word = cur.adv;
    o_pme_n = !cur.wake_status;
    o_xcvr_reset = cur.xc[XC_RESET_BIT];
    o_led_speed = eff_100 && i_link_up;
    o_led_link_act = (act && !collide) ? blink10 : i_link_up;
    o_led_fd_col = collide ? blink20 : eff_fd;
    o_led_link100 = cur.cfg[CFG_LED4_BIT] && i_link_up && eff_100;
    o_led_link10 = cur.cfg[CFG_LED4_BIT] && i_link_up && !eff_100;
    o_led_act = cur.cfg[CFG_LED4_BIT] && act && blink10;
  end

endmodule
`default_nettype wire

/* File: lan_ctl_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module lan_ctl_monitor
  import lan_ctl_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic i_tx_active,
  input wire logic o_tx_frame_go,
  input wire logic o_col,
  input wire logic i_rx_valid,
  input wire logic i_rx_eof,
  input wire logic i_rx_crc_ok,
  input wire logic i_rx_addr_ok,
  input wire logic o_paused,
  input wire logic o_pme_n,
  input wire logic o_xcvr_reset,
  input wire logic [15:0] o_flp_word,
  input wire logic o_led_speed
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);
  logic [15:0] pause_cnt;
  logic good_eof;
  logic host_rst;
  logic pme_clr;
  assign good_eof = i_rx_valid && i_rx_eof && i_rx_crc_ok && i_rx_addr_ok;
  assign host_rst = i_wr && i_addr == ADDR_HOST_CTRL && i_wdata[HOST_SW_RESET_BIT];
  assign pme_clr = i_wr && i_addr == ADDR_POWER_STATUS && i_wdata[PWR_WAKE_STATUS_BIT];
  // Cycles spent paused, saturating
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pause_cnt <= 16'h0000;
    end else if (!o_paused) begin
      pause_cnt <= 16'h0000;
    end else if (pause_cnt != 16'hffff) begin
      pause_cnt <= pause_cnt + 16'h0001;
    end
  end
  a_col_needs_tx: assert property (o_col |-> i_tx_active)
    else $error("collision without transmit");
  a_pause_holds_tx: assert property (
    o_paused && pause_cnt > (o_led_speed ? 16'h0202 : 16'h1402) |-> !o_tx_frame_go)
    else $error("frame start granted late in pause");
  a_pause_cause: assert property ($rose(o_paused) |-> $past(good_eof))
    else $error("pause without received frame");
  a_wake_cause: assert property ($fell(o_pme_n) |-> $past(good_eof))
    else $error("wake event without good frame");
  a_wake_sticky: assert property (
    !o_pme_n && !pme_clr && !host_rst && !$past(host_rst) |=> !o_pme_n)
    else $error("wake event dropped by itself");
  a_host_reset: assert property (host_rst |-> ##2 o_pme_n && !o_paused)
    else $error("software reset left state");
  a_host_selfclr: assert property (i_rd && i_addr == ADDR_HOST_CTRL |=> !o_rdata[0])
    else $error("reset bit not self cleared");
  a_xcvr_pulse: assert property (
    i_wr && i_addr == ADDR_XCVR_CTRL && i_wdata[XC_RESET_BIT] |=> o_xcvr_reset ##1 !o_xcvr_reset)
    else $error("transceiver reset pulse wrong");
  a_adv_word: assert property (
    i_rd && i_addr == ADDR_XCVR_ADV |=> o_rdata[15:0] == $past(o_flp_word))
    else $error("burst word differs from advertisement");
  c_pause: cover property ($rose(o_paused));
  c_wake: cover property ($fell(o_pme_n));
  c_col: cover property (o_col);
endmodule
bind lan_link_flow_wake_control lan_ctl_monitor mon (
  .i_sys_clk, .i_reset_n, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_tx_active,
  .o_tx_frame_go, .o_col, .i_rx_valid, .i_rx_eof, .i_rx_crc_ok, .i_rx_addr_ok,
  .o_paused, .o_pme_n, .o_xcvr_reset, .o_flp_word, .o_led_speed
);
`default_nettype wire

/* File: link_partner_model.sv */
`timescale 1ns/10ps
`default_nettype none
module link_partner_model
  import lan_ctl_pkg::*;
(
  input wire logic i_sys_clk,
  output rx_byte_t o_rx,
  output logic o_rx_bit,
  output logic [4:0] o_rx_code,
  output logic o_rx_code_valid,
  output logic o_link_up,
  output logic o_partner_valid,
  output logic [15:0] o_partner_ability
);
  initial begin
    o_rx = '0;
    o_rx_bit = 1'b1;
    o_rx_code = 5'h00;
    o_rx_code_valid = 1'b0;
    o_link_up = 1'b0;
    o_partner_valid = 1'b0;
    o_partner_ability = 16'h0000;
  end
  // After a frame the data lines show the inverse of its last byte; before the first frame they are zero
  task automatic send_frame(input logic [7:0] b[$], input logic good);
    for (int i = 0; i < b.size(); i++) begin
      @(posedge i_sys_clk);
      o_rx <= '{1'b1, i == 0, i == b.size() - 1, good, 1'b1, b[i]};
    end
    @(posedge i_sys_clk);
    o_rx <= '{1'b0, 1'b1, 1'b1, ~good, 1'b0, ~b[b.size() - 1]};
  endtask
  task automatic send_ability(input logic [15:0] w);
    @(posedge i_sys_clk);
    o_partner_valid <= 1'b1;
    o_partner_ability <= w;
    o_link_up <= 1'b1;
    @(posedge i_sys_clk);
    o_partner_valid <= 1'b0;
    o_partner_ability <= ~w;
  endtask
  task automatic send_bits(input logic [9:0] v);
    for (int i = 9; i >= 0; i--) begin
      @(posedge i_sys_clk);
      o_rx_bit <= v[i];
    end
    @(posedge i_sys_clk);
    o_rx_bit <= 1'b1;
  endtask
  task automatic send_code(input logic [4:0] c);
    @(posedge i_sys_clk);
    o_rx_code <= c;
    o_rx_code_valid <= 1'b1;
    @(posedge i_sys_clk);
    o_rx_code <= ~c;
    o_rx_code_valid <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import lan_ctl_pkg::*;
;
  localparam logic [47:0] STN = 48'h0a0b0c0d0e0f;
  logic i_sys_clk, i_reset_n, i_wr, i_rd, i_tx_active, i_tx_frame_req, i_tx_line_bit;
  logic [7:0] i_addr;
  logic [31:0] i_wdata, o_rdata, st;
  logic o_tx_frame_go, o_line_bit, o_line_idle, o_loop_bit, o_loop_100, o_flp_send;
  logic o_crs, o_col, o_paused, o_led_speed, o_led_link_act, o_led_fd_col;
  logic o_led_link100, o_led_link10, o_led_act, o_pme_n, o_xcvr_reset;
  logic [15:0] o_flp_word;
  logic i_rx_bit, i_rx_code_valid, i_link_up, i_partner_valid;
  logic [4:0] i_rx_code;
  logic [15:0] i_partner_ability;
  rx_byte_t rx;
  logic [7:0] fr[$];
  int err_count = 0;
  int checks_done = 0;
  link_partner_model lp (.i_sys_clk, .o_rx(rx), .o_rx_bit(i_rx_bit), .o_rx_code(i_rx_code),
    .o_rx_code_valid(i_rx_code_valid), .o_link_up(i_link_up),
    .o_partner_valid(i_partner_valid), .o_partner_ability(i_partner_ability));
  lan_link_flow_wake_control dut (.i_sys_clk, .i_reset_n, .i_addr, .i_wdata, .i_wr, .i_rd,
    .o_rdata, .i_rx_bit, .i_rx_code, .i_rx_code_valid, .i_tx_active, .i_tx_frame_req,
    .o_tx_frame_go, .i_tx_line_bit, .o_line_bit, .o_line_idle, .o_loop_bit, .o_loop_100,
    .i_link_up, .i_partner_valid, .i_partner_ability, .o_flp_send, .o_flp_word, .o_crs,
    .o_col, .i_rx_valid(rx.valid), .i_rx_sof(rx.sof), .i_rx_eof(rx.eof),
    .i_rx_crc_ok(rx.crc_ok), .i_rx_addr_ok(rx.addr_ok), .i_rx_data(rx.data), .o_paused,
    .o_led_speed, .o_led_link_act, .o_led_fd_col, .o_led_link100, .o_led_link10,
    .o_led_act, .o_pme_n, .o_xcvr_reset);
  initial begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end
  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t register %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t pin %b expected %b", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    #1;
    d = o_rdata;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    chk32(d & m, e);
  endtask
  task automatic negotiate(input logic [15:0] w);
    lp.send_ability(w);
    st = '0;
    for (int n = 0; n < 20 && !st[2]; n++) begin
      rd(ADDR_LINK_STATUS, st);
    end
  endtask
  task automatic pause(input logic [15:0] op, input logic [15:0] t, input logic good);
    fr = '{8'h01, 8'h80, 8'hc2, 8'h00, 8'h00, 8'h01, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h07, CTRL_TYPE[15:8], CTRL_TYPE[7:0], op[15:8], op[7:0], t[15:8], t[7:0]};
    lp.send_frame(fr, good);
    tick(1);
  endtask
  task automatic wake(input logic good);
    fr = '{};
    for (int r = 0; r < 19; r++) begin
      for (int j = 0; j < 6; j++) begin
        fr.push_back(r == 1 ? 8'h02 : r == 2 ? 8'hff : STN[47 - 8 * j -: 8]);
      end
    end
    lp.send_frame(fr, good);
    tick(1);
  endtask
  initial begin
    #400000;
    err_count++;
    conclude();
  end
  initial begin
    logic [15:0] abil[4] = '{16'h05e1, 16'h00e1, 16'h0061, 16'h0021};
    logic [31:0] res[4] = '{32'h18, 32'h08, 32'h10, 32'h00};
    {i_addr, i_wdata, i_wr, i_rd, i_tx_active, i_tx_frame_req, i_tx_line_bit} = '0;
    i_reset_n = 1'b0;
    repeat (8) @(posedge i_sys_clk);
    i_reset_n <= 1'b1;
    rdc(ADDR_XCVR_CTRL, 32'hffff, 32'h3100);
    rdc(ADDR_XCVR_ADV, 32'hffff, 32'h05e1);
    wr(8'h04, 32'hffff_ffff);
    rdc(8'h04, 32'hffff_ffff, 32'h0);
    chk1(o_flp_send, 1'b1);
    chk32({16'h0, o_flp_word}, 32'h05e1);
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_XCVR_CTRL, 32'h0000_b100);
      rdc(ADDR_XCVR_CTRL, 32'hffff, 32'h3100);
      chk1(o_flp_send, 1'b1);
      negotiate(abil[k]);
      chk32(st & 32'h18, res[k]);
    end
    pause(PAUSE_OPCODE, 16'h0005, 1'b1);
    chk1(o_paused, 1'b0);
    i_tx_active <= 1'b1;
    tick(2);
    chk1(o_crs, 1'b1);
    lp.send_bits(10'b1111001111);
    tick(1);
    chk1(o_col, 1'b0);
    lp.send_bits(10'b1011111011);
    tick(1);
    chk1(o_col, 1'b1);
    i_tx_active <= 1'b0;
    lp.send_code(CODE_IDLE);
    tick(1);
    chk1(o_crs, 1'b0);
    lp.send_bits(10'b1011111011);
    tick(1);
    chk1(o_crs, 1'b1);
    lp.send_code(CODE_ESD_T);
    tick(1);
    chk1(o_crs, 1'b0);
    wr(ADDR_XCVR_CTRL, 32'h2100);
    tick(2);
    chk1(o_flp_send, 1'b0);
    rdc(ADDR_LINK_STATUS, 32'h18, 32'h18);
    i_tx_active <= 1'b1;
    tick(2);
    chk1(o_crs, 1'b0);
    lp.send_bits(10'b1011111011);
    tick(1);
    chk1(o_col, 1'b0);
    lp.send_code(CODE_IDLE);
    i_tx_line_bit <= 1'b1;
    for (int s = 0; s < 2; s++) begin
      wr(ADDR_XCVR_CTRL, 32'h4000 | (s << XC_SPEED_BIT));
      tick(1);
      chk1(o_line_bit, 1'b0);
      chk1(o_line_idle, 1'b1);
      chk1(o_loop_bit, 1'b1);
      chk1(o_loop_100, s[0]);
    end
    wr(ADDR_XCVR_CTRL, 32'h3100);
    tick(1);
    chk1(o_line_bit, 1'b1);
    chk1(o_line_idle, 1'b0);
    i_tx_active <= 1'b0;
    chk1(o_flp_send, 1'b1);
    negotiate(16'h05e1);
    chk32(st & 32'h5c, 32'h5c);
    chk1(o_led_speed, 1'b1);
    pause(16'h0002, 16'h0005, 1'b1);
    chk1(o_paused, 1'b0);
    pause(PAUSE_OPCODE, 16'h0005, 1'b0);
    chk1(o_paused, 1'b0);
    pause(PAUSE_OPCODE, 16'h0002, 1'b1);
    chk1(o_paused, 1'b1);
    i_tx_frame_req <= 1'b1;
    tick(530);
    chk1(o_tx_frame_go, 1'b0);
    for (int n = 0; n < 600 && o_paused === 1'b1; n++) tick(1);
    chk1(o_tx_frame_go, 1'b1);
    i_tx_frame_req <= 1'b0;
    pause(PAUSE_OPCODE, 16'hffff, 1'b1);
    chk1(o_paused, 1'b1);
    pause(PAUSE_OPCODE, 16'h0000, 1'b1);
    chk1(o_paused, 1'b0);
    wr(ADDR_CONFIG_CTRL, 32'h1);
    tick(1);
    chk1(o_led_link100, 1'b1);
    chk1(o_led_link10, 1'b0);
    chk1(o_led_link_act, 1'b1);
    chk1(o_led_fd_col, 1'b1);
    chk1(o_led_act, 1'b0);
    wr(ADDR_STATION_HI, {16'h0, STN[47:32]});
    wr(ADDR_STATION_LO, STN[31:0]);
    wr(ADDR_CONFIG_CTRL, 32'h0004_0001);
    wake(1'b1);
    chk1(o_pme_n, 1'b0);
    rdc(ADDR_POWER_STATUS, 32'h8000, 32'h8000);
    wr(ADDR_POWER_STATUS, 32'h8000);
    tick(1);
    chk1(o_pme_n, 1'b1);
    wake(1'b0);
    chk1(o_pme_n, 1'b1);
    wake(1'b1);
    wr(ADDR_HOST_CTRL, 32'h1);
    tick(1);
    chk1(o_pme_n, 1'b1);
    rdc(ADDR_HOST_CTRL, 32'h1, 32'h0);
    rdc(ADDR_CONFIG_CTRL, 32'hffff_ffff, 32'h0);
    wake(1'b1);
    chk1(o_pme_n, 1'b1);
    conclude();
  end
endmodule
`default_nettype wire
